// ===== shared/converter_alarm_regs.vh
`ifndef CONVERTER_ALARM_REGS_VH
`define CONVERTER_ALARM_REGS_VH

// register addresses on the internal register port
`define ADDR_BIT_FAILURES   7'h04
`define ADDR_ALARM_FLAGS    7'h05
`define ADDR_ALARM_MASK     7'h07

// reset values
`define RST_BIT_FAILURES    16'h0000
`define RST_ALARM_FLAGS     16'h0000
`define RST_ALARM_MASK      16'hFFFF

// alarm flag bit positions
`define BIT_ZERO_CHECK      15
`define BIT_FIFO_COLLIDE    13
`define BIT_FIFO_ONE_AWAY   12
`define BIT_FIFO_TWO_AWAY   11
`define BIT_DACCLK_GONE     10
`define BIT_DATACLK_GONE    9
`define BIT_OUTPUT_GONE     8
`define BIT_PATTERN_FAIL    7
`define BIT_PLL_UNLOCK      5
`define BIT_RISE_PARITY     4
`define BIT_FALL_PARITY     3
`define BIT_FRAME_PARITY    2

// bits that exist in the alarm flag register (14, 6, 1, 0 reserved)
`define ALARM_USED_MASK     16'hBFBC

// code forced on the converter while outputs are shut off
`define MID_SCALE_CODE      16'h8000

// data clock loss: no edge seen for this long counts as a stopped clock
`define SYS_CLK_MHZ         125
`define DATACLK_LOSS_NS     1000
`define DATACLK_LOSS_CYC    ((`DATACLK_LOSS_NS * `SYS_CLK_MHZ + 999) / 1000)

`endif

// ===== core/pin_sync3.v
`timescale 1ns/1ps

// three-stage synchroniser: the clean level moves only when stages two
// and three agree, so a single metastable sample never reaches logic
module pin_sync3 #(
  parameter RESET_LEVEL = 1'b0
) (
  input  wire sys_clk,   // system clock
  input  wire rst,       // async reset, active high
  input  wire pinIn,     // asynchronous input
  output reg  level_r,   // filtered level
  output reg  rise_r,    // one-cycle pulse on a rising change
  output reg  fall_r     // one-cycle pulse on a falling change
);

  reg stage1_r;
  reg stage2_r;
  reg stage3_r;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1_r <= RESET_LEVEL;
      stage2_r <= RESET_LEVEL;
      stage3_r <= RESET_LEVEL;
      level_r  <= RESET_LEVEL;
      rise_r   <= 1'b0;
      fall_r   <= 1'b0;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      rise_r   <= 1'b0;
      fall_r   <= 1'b0;
      if (stage2_r == stage3_r && stage3_r != level_r) begin
        level_r <= stage3_r;
        rise_r  <= stage3_r;
        fall_r  <= ~stage3_r;
      end
    end
  end

endmodule

// ===== core/converter_alarm_status_bank.v
// Functional notes
// (RULE1) bit i of failure register sets when data line i fails the compare
// (RULE2) failure register at 0x04 has no defined start value; host write clears it
// (RULE3) failure results are captured only while pattern checker enable is set
// (RULE4) all-zero 8-bit write pointer sets bit 15; pointer stays stuck till sync
// (RULE5) host resynchronises the FIFO after a zero-check alarm
// (RULE6) bits 13:11 give pointer distance: 001 two away, 01x one, 1xx collide
// (RULE7) enabled collision keeps outputs off until resync and bits cleared
// (RULE8) converter clock stop sets bit 10; enabled, host restores clock and clears
// (RULE9) data clock stop sets bit 9; enabled, host restores clock and clears
// (RULE10) bit 8 sets whenever converter clock, data clock or collision alarm is set
// (RULE11) while shutdown is active every converter output carries 0x8000
// (RULE12) after an enabled shutdown host fixes causes and clears alarm bits
// (RULE13) bit 7 sets when received data mismatches the expected pattern
// (RULE14) in pattern checker mode only bit 7 is meaningful to the host
// (RULE15) bit 5 sets on PLL unlock; old revisions use loop filter voltage
// (RULE16) bit 4 sets on rising-edge data parity error
// (RULE17) bit 3 sets on falling-edge data parity error
// (RULE18) bit 2 sets on parity error with frame used as parity bit
// (RULE19) alarm register at 0x05 starts setup dependent; host write clears it
// (RULE20) converter clock loss shuts off only if enabled and bits 10, 8 unmasked
// (RULE21) mask register bit per alarm, one masks, all masked after reset
// (RULE22) alarm bits are sticky; writing one clears that bit
// (RULE23) reserved bits 14, 6, 1, 0 read zero and ignore writes
`timescale 1ns/1ps
`include "converter_alarm_regs.vh"

module converter_alarm_status_bank #(
  parameter ADDR_W     = 7,
  parameter DATA_W     = 16,
  parameter PTR_W      = 8,
  parameter LOSS_CYC_W = 12
) (
  input  wire              sys_clk,          // system clock, 125 MHz
  input  wire              rst,              // async reset, active high
  input  wire              regWrEn,          // register write strobe
  input  wire [ADDR_W-1:0] regAddr,          // register address
  input  wire [DATA_W-1:0] regWrData,        // register write data
  output reg  [DATA_W-1:0] regRdData_r,      // read data, one cycle after address
  input  wire              patternCheckEna,  // pattern checker enable
  input  wire              dacClkGoneEna,    // converter clock loss may shut off
  input  wire              dataClkGoneEna,   // data clock loss may shut off
  input  wire              collisionGoneEna, // fifo collision may shut off
  input  wire [DATA_W-1:0] lineFail,         // per-line compare failure pulses
  input  wire              patternMismatch,  // word mismatch pulse
  input  wire [PTR_W-1:0]  fifoWrPtr,        // one-hot fifo write pointer
  input  wire [PTR_W-1:0]  fifoRdPtr,        // one-hot fifo read pointer
  input  wire              riseParityErr,    // rising edge parity error pulse
  input  wire              fallParityErr,    // falling edge parity error pulse
  input  wire              frameParityErr,   // frame parity error pulse
  input  wire              dataClkPin,       // input data clock, sampled
  input  wire              dacClkGonePin,    // clock monitor converter clock gone
  input  wire              pllLockPin,       // pll lock indication
  input  wire [DATA_W-1:0] dataInA,          // channel A data
  input  wire [DATA_W-1:0] dataInB,          // channel B data
  output reg  [DATA_W-1:0] dacOutA_r,        // channel A converter code
  output reg  [DATA_W-1:0] dacOutB_r,        // channel B converter code
  output reg               outputShutOff_r,  // outputs forced to mid scale
  output reg               wrPtrStuck_r      // write pointer invalid, resync needed
);

  // the count is worked out in 32 bits and cut to the counter width here
  localparam integer          LOSS_CYC_INT = `DATACLK_LOSS_CYC;
  localparam [LOSS_CYC_W-1:0] LOSS_CYC     = LOSS_CYC_INT[LOSS_CYC_W-1:0];
  localparam [LOSS_CYC_W-1:0] LOSS_LAST    = LOSS_CYC - 1'b1;

  // link clock and asynchronous status pins
  wire dataClkLevel;
  wire dataClkRise;
  wire dataClkFall;
  wire dacClkGoneLevel;
  wire pllLockLevel;
  wire pllLockFall;

  pin_sync3 #(.RESET_LEVEL(1'b0)) dataClkSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   (dataClkPin),
    .level_r (dataClkLevel),
    .rise_r  (dataClkRise),
    .fall_r  (dataClkFall)
  );

  pin_sync3 #(.RESET_LEVEL(1'b0)) dacClkGoneSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   (dacClkGonePin),
    .level_r (dacClkGoneLevel),
    .rise_r  (),
    .fall_r  ()
  );

  // lock is assumed present at reset so a slow pll start is seen as a fall
  pin_sync3 #(.RESET_LEVEL(1'b1)) pllLockSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pinIn   (pllLockPin),
    .level_r (pllLockLevel),
    .rise_r  (),
    .fall_r  (pllLockFall)
  );

  // data clock watchdog: the counter restarts on every edge of the pin
  // the pin is sampled and needs two equal samples, so a data clock faster than a quarter of sys_clk reads as lost
  reg [LOSS_CYC_W-1:0] lossCount_r;
  reg [LOSS_CYC_W-1:0] lossCount_nxt;
  reg                  dataClkGone_r;
  reg                  dataClkGone_nxt;

  always @* begin
    lossCount_nxt   = lossCount_r;
    dataClkGone_nxt = dataClkGone_r;
    if (dataClkRise || dataClkFall) begin
      lossCount_nxt   = {LOSS_CYC_W{1'b0}};
      dataClkGone_nxt = 1'b0;
    end else if (lossCount_r >= LOSS_LAST) begin
      dataClkGone_nxt = 1'b1;
    end else begin
      lossCount_nxt = lossCount_r + 1'b1;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lossCount_r <= {LOSS_CYC_W{1'b0}};
    end else begin
      lossCount_r <= lossCount_nxt;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataClkGone_r <= 1'b0;
    end else begin
      dataClkGone_r <= dataClkGone_nxt;
    end
  end

  // fifo pointer distance from the two one-hot rings
  function [PTR_W-1:0] rotl;
    input [PTR_W-1:0] v;
    input integer     n;
    integer           k;
    begin
      for (k = 0; k < PTR_W; k = k + 1) begin
        rotl[(k + n) % PTR_W] = v[k];
      end
    end
  endfunction

  // rotating one ring and matching the other gives the distance either way
  wire [PTR_W-1:0] wrRot1 = rotl(fifoWrPtr, 1);
  wire [PTR_W-1:0] rdRot1 = rotl(fifoRdPtr, 1);
  wire [PTR_W-1:0] wrRot2 = rotl(fifoWrPtr, 2);
  wire [PTR_W-1:0] rdRot2 = rotl(fifoRdPtr, 2);

  wire ptrCollide = |(fifoWrPtr & fifoRdPtr);
  wire ptrOneAway = |(wrRot1 & fifoRdPtr) | |(rdRot1 & fifoWrPtr);
  wire ptrTwoAway = |(wrRot2 & fifoRdPtr) | |(rdRot2 & fifoWrPtr);
  wire ptrZero    = ~|fifoWrPtr;

  // distance code, nearest first: a collision hides the nearness bits
  reg [2:0] fifoDist;

  always @* begin
    if (ptrCollide) begin
      fifoDist = 3'h4;
    end else if (ptrOneAway) begin
      fifoDist = 3'h2;
    end else if (ptrTwoAway) begin
      fifoDist = 3'h1;
    end else begin
      fifoDist = 3'h0;
    end
  end

  // raw events, one bit per alarm position except output-gone bit 8, which is derived below
  reg [DATA_W-1:0] alarmEvent;

  always @* begin
    alarmEvent                     = {DATA_W{1'b0}};
    alarmEvent[`BIT_ZERO_CHECK]    = ptrZero;                   // RULE4
    alarmEvent[`BIT_FIFO_COLLIDE]  = fifoDist[2];               // RULE6
    alarmEvent[`BIT_FIFO_ONE_AWAY] = fifoDist[1];               // RULE6
    alarmEvent[`BIT_FIFO_TWO_AWAY] = fifoDist[0];               // RULE6
    alarmEvent[`BIT_DACCLK_GONE]   = dacClkGoneLevel;           // RULE8
    alarmEvent[`BIT_DATACLK_GONE]  = dataClkGone_r;             // RULE9
    // pattern mode hides nothing here; the host ignores the other bits
    alarmEvent[`BIT_PATTERN_FAIL]  = patternMismatch;           // RULE13 RULE14
    alarmEvent[`BIT_PLL_UNLOCK]    = pllLockFall | ~pllLockLevel; // RULE15
    alarmEvent[`BIT_RISE_PARITY]   = riseParityErr;             // RULE16
    alarmEvent[`BIT_FALL_PARITY]   = fallParityErr;             // RULE17
    alarmEvent[`BIT_FRAME_PARITY]  = frameParityErr;            // RULE18
  end

  // register state
  reg [DATA_W-1:0] bitFailures_r;
  reg [DATA_W-1:0] bitFailures_nxt;
  reg [DATA_W-1:0] alarmFlags_r;
  reg [DATA_W-1:0] alarmFlags_nxt;
  reg [DATA_W-1:0] alarmMask_r;
  reg [DATA_W-1:0] alarmMask_nxt;

  wire wrFailures = regWrEn && (regAddr == `ADDR_BIT_FAILURES);
  wire wrFlags    = regWrEn && (regAddr == `ADDR_ALARM_FLAGS);
  wire wrMask     = regWrEn && (regAddr == `ADDR_ALARM_MASK);

  // the output-gone bit follows its three causes, including ones that
  // arrive in this same cycle, so it never lags the alarm that caused it
  wire causeNow = alarmEvent[`BIT_DACCLK_GONE] | alarmEvent[`BIT_DATACLK_GONE] |
                  alarmEvent[`BIT_FIFO_COLLIDE];

  always @* begin
    bitFailures_nxt = bitFailures_r;
    if (wrFailures) begin
      bitFailures_nxt = bitFailures_r & ~regWrData;              // RULE2
    end
    if (patternCheckEna) begin
      bitFailures_nxt = bitFailures_nxt | lineFail;              // RULE1 RULE3
    end
  end

  always @* begin
    alarmFlags_nxt = alarmFlags_r;
    // writing zeros leaves a flag alone, so a partial clear cannot lose events
    if (wrFlags) begin
      alarmFlags_nxt = alarmFlags_r & ~regWrData;                // RULE19 RULE22
    end
    // a new event wins over a clear in the same cycle
    alarmFlags_nxt = alarmFlags_nxt | alarmEvent;                // RULE22
    if (causeNow || alarmFlags_nxt[`BIT_DACCLK_GONE] ||
        alarmFlags_nxt[`BIT_DATACLK_GONE] || alarmFlags_nxt[`BIT_FIFO_COLLIDE]) begin
      alarmFlags_nxt[`BIT_OUTPUT_GONE] = 1'b1;                   // RULE10
    end
    alarmFlags_nxt = alarmFlags_nxt & `ALARM_USED_MASK;          // RULE23
  end

  // the mask only gates shutdown, never the flags themselves
  always @* begin
    alarmMask_nxt = alarmMask_r;
    if (wrMask) begin
      alarmMask_nxt = regWrData;                                 // RULE21
    end
  end

  // failure bits have no meaningful start value; zero keeps reads defined
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bitFailures_r <= `RST_BIT_FAILURES;
    end else begin
      bitFailures_r <= bitFailures_nxt;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alarmFlags_r <= `RST_ALARM_FLAGS;
    end else begin
      alarmFlags_r <= alarmFlags_nxt;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alarmMask_r <= `RST_ALARM_MASK;                            // RULE21
    end else begin
      alarmMask_r <= alarmMask_nxt;
    end
  end

  // shutdown: a cause counts only when its enable is set and both it and
  // the output-gone alarm are unmasked
  wire dacClkCause  = alarmFlags_r[`BIT_DACCLK_GONE] & dacClkGoneEna &
                      ~alarmMask_r[`BIT_DACCLK_GONE];            // RULE20 RULE8
  wire dataClkCause = alarmFlags_r[`BIT_DATACLK_GONE] & dataClkGoneEna &
                      ~alarmMask_r[`BIT_DATACLK_GONE];           // RULE9
  wire collideCause = alarmFlags_r[`BIT_FIFO_COLLIDE] & collisionGoneEna &
                      ~alarmMask_r[`BIT_FIFO_COLLIDE];           // RULE7
  wire shutOffNxt   = alarmFlags_r[`BIT_OUTPUT_GONE] & ~alarmMask_r[`BIT_OUTPUT_GONE] &
                      (dacClkCause | dataClkCause | collideCause); // RULE20

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outputShutOff_r <= 1'b0;
    end else begin
      outputShutOff_r <= shutOffNxt;                             // RULE20
    end
  end

  // held until software clears the flags, which drops shutOffNxt
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dacOutA_r <= `MID_SCALE_CODE;
    end else if (shutOffNxt) begin
      dacOutA_r <= `MID_SCALE_CODE;                              // RULE11
    end else begin
      dacOutA_r <= dataInA;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dacOutB_r <= `MID_SCALE_CODE;
    end else if (shutOffNxt) begin
      dacOutB_r <= `MID_SCALE_CODE;                              // RULE11
    end else begin
      dacOutB_r <= dataInB;
    end
  end

  // stuck pointer persists until the fifo logic reloads a valid one
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtrStuck_r <= 1'b0;
    end else begin
      wrPtrStuck_r <= ptrZero;                                   // RULE4
    end
  end

  // read port: reserved alarm flag bits are never stored, so they read as zero
  reg [DATA_W-1:0] readMux;

  always @* begin
    // reads have no side effect; only writes clear flags
    case (regAddr)
      `ADDR_BIT_FAILURES: begin
        readMux = bitFailures_r;
      end
      `ADDR_ALARM_FLAGS: begin
        readMux = alarmFlags_r;                                  // RULE23
      end
      `ADDR_ALARM_MASK: begin
        readMux = alarmMask_r;
      end
      // unmapped addresses read as zero
      default: begin
        readMux = {DATA_W{1'b0}};
      end
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData_r <= {DATA_W{1'b0}};
    end else begin
      regRdData_r <= readMux;
    end
  end

endmodule

// ===== dv/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
  input  wire run,     // data clock runs while high
  output reg  dataClk  // data clock towards the device
);
  // offset start keeps the clock edges clear of the system clock edges
  initial begin
    dataClk = 1'b0;
    #3;
    forever #80 if (run) dataClk = ~dataClk;
  end
endmodule

// ===== dv/converter_alarm_status_bank_sva.sv
`timescale 1ns/1ps
module alarm_bank_sva (
  input wire        sys_clk,          // system clock
  input wire        rst,              // async reset
  input wire [6:0]  regAddr,          // register address
  input wire [15:0] regRdData_r,      // read data
  input wire        patternCheckEna,  // checker enable
  input wire        dacClkGoneEna,    // shutdown enable
  input wire        dataClkGoneEna,   // shutdown enable
  input wire        collisionGoneEna, // shutdown enable
  input wire [15:0] lineFail,         // line fail pulses
  input wire        patternMismatch,  // mismatch pulse
  input wire        riseParityErr,    // parity pulse
  input wire [7:0]  fifoWrPtr,        // write pointer
  input wire [7:0]  fifoRdPtr,        // read pointer
  input wire [15:0] dataInA,          // channel data
  input wire [15:0] dacOutA_r,        // channel code
  input wire [15:0] dacOutB_r,        // channel code
  input wire        outputShutOff_r,  // shutdown flag
  input wire        wrPtrStuck_r      // pointer stuck
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_mid_scale:
    assert property (outputShutOff_r |-> dacOutA_r == 16'h8000 && dacOutB_r == 16'h8000)
    else $error("outputs not at mid scale");
  a_pass_data:
    assert property (!outputShutOff_r && !$past(rst) |-> dacOutA_r == $past(dataInA))
    else $error("channel data not passed");
  a_stuck_follow:
    assert property (1'b1 |=> wrPtrStuck_r == ($past(fifoWrPtr) == 8'h00))
    else $error("stuck flag wrong");
  a_reserved_zero:
    assert property (regAddr == 7'h05 |=> (regRdData_r & 16'h4043) == 16'h0000)
    else $error("reserved bit set");
  a_shut_enabled:
    assert property (outputShutOff_r |-> $past(collisionGoneEna || dacClkGoneEna || dataClkGoneEna))
    else $error("shutdown without enable");
  a_mismatch_flag:
    assert property (patternMismatch ##1 regAddr == 7'h05 |=> regRdData_r[7])
    else $error("mismatch flag missing");
  a_rise_parity:
    assert property (riseParityErr ##1 regAddr == 7'h05 |=> regRdData_r[4])
    else $error("parity flag missing");
  a_collide_flag:
    assert property ((fifoWrPtr == fifoRdPtr && fifoWrPtr != 8'h00) ##1 regAddr == 7'h05
      |=> regRdData_r[13] && regRdData_r[8])
    else $error("collision flags missing");
  a_line_fail:
    assert property (patternCheckEna ##1 regAddr == 7'h04
      |=> (regRdData_r & $past(lineFail, 2)) == $past(lineFail, 2))
    else $error("line fail bits missing");
  c_shut: cover property ($rose(outputShutOff_r));
  c_stuck: cover property ($rose(wrPtrStuck_r));
  c_collide: cover property (fifoWrPtr == fifoRdPtr);
endmodule
bind converter_alarm_status_bank alarm_bank_sva u_sva (.*);

// ===== dv/tb_converter_alarm_status_bank.sv
`timescale 1ns/1ps
module tb_converter_alarm_status_bank;
  reg         sys_clk, rst, regWrEn, patternCheckEna, linkRun, patternMismatch;
  reg         dacClkGoneEna, dataClkGoneEna, collisionGoneEna, dacClkGonePin, pllLockPin;
  reg         riseParityErr, fallParityErr, frameParityErr;
  reg  [6:0]  regAddr;
  reg  [15:0] regWrData, lineFail, dataInA, dataInB, rv;
  reg  [7:0]  fifoWrPtr, fifoRdPtr;
  reg  [31:0] seed;
  wire        dataClkPin, outputShutOff_r, wrPtrStuck_r;
  wire [15:0] regRdData_r, dacOutA_r, dacOutB_r;
  integer     errors, n_compared, i;

  converter_alarm_status_bank u_dut (
    .sys_clk(sys_clk), .rst(rst), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData_r(regRdData_r), .patternCheckEna(patternCheckEna),
    .dacClkGoneEna(dacClkGoneEna), .dataClkGoneEna(dataClkGoneEna),
    .collisionGoneEna(collisionGoneEna), .lineFail(lineFail),
    .patternMismatch(patternMismatch), .fifoWrPtr(fifoWrPtr), .fifoRdPtr(fifoRdPtr),
    .riseParityErr(riseParityErr), .fallParityErr(fallParityErr),
    .frameParityErr(frameParityErr), .dataClkPin(dataClkPin),
    .dacClkGonePin(dacClkGonePin), .pllLockPin(pllLockPin), .dataInA(dataInA),
    .dataInB(dataInB), .dacOutA_r(dacOutA_r), .dacOutB_r(dacOutB_r),
    .outputShutOff_r(outputShutOff_r), .wrPtrStuck_r(wrPtrStuck_r));
  host_link_model u_host (.run(linkRun), .dataClk(dataClkPin));

  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // expected pointer field from the ring distance of the two one-hot positions
  function [15:0] dist_flags(input [7:0] w, input [7:0] r);
    integer a, b, d;
    begin
      a = 0;
      b = 0;
      for (d = 0; d < 8; d = d + 1) begin
        if (w[d]) a = d;
        if (r[d]) b = d;
      end
      d = (a - b + 8) % 8;
      if (d == 0) dist_flags = 16'h2100;
      else if (d == 1 || d == 7) dist_flags = 16'h1000;
      else if (d == 2 || d == 6) dist_flags = 16'h0800;
      else dist_flags = 16'h0000;
    end
  endfunction
  task chk(input [15:0] seen, input [15:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  task shut(input e);
    chk({15'h0000, outputShutOff_r}, {15'h0000, e});
  endtask
  task wr(input [6:0] a, input [15:0] d);
    tick(1);
    {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    tick(1);
    regWrEn = 1'b0;
  endtask
  task rdchk(input [6:0] a, input [15:0] exp);
    tick(1);
    regAddr = a;
    tick(1);
    chk(regRdData_r, exp);
  endtask
  // clearing with all ones wipes every sticky alarm bit, then every failure bit in a second write
  task clr;
    wr(7'h05, 16'hffff);
    wr(7'h04, 16'hffff);
  endtask
  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    errors = errors + 1;
    give_verdict;
  end
  initial begin
    {errors, n_compared, seed, rst, linkRun, pllLockPin} = {32'h0, 32'h0, 32'h0000_decd, 3'h7};
    {regWrEn, patternCheckEna, dacClkGoneEna, dataClkGoneEna, collisionGoneEna} = 5'h00;
    {patternMismatch, riseParityErr, fallParityErr, frameParityErr, dacClkGonePin} = 5'h00;
    {regAddr, regWrData, lineFail, dataInA, dataInB} = 71'h0;
    {fifoWrPtr, fifoRdPtr} = 16'h0110;
    repeat (16) @(posedge sys_clk);
    tick(1);
    rst = 1'b0;
    tick(8);
    rdchk(7'h07, 16'hffff);
    rdchk(7'h06, 16'h0000);
    clr;
    rdchk(7'h05, 16'h0000);
    rdchk(7'h04, 16'h0000);
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1) begin
      seed = lfsr(seed);
      tick(1);
      {dataInB, dataInA} = seed;
      tick(2);
      chk(dacOutA_r, dataInA);
      chk(dacOutB_r, dataInB);
    end
    patternCheckEna = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      seed = lfsr(seed);
      rv = seed[15:0] | 16'h8001;
      tick(1);
      lineFail = rv;
      tick(1);
      lineFail = 16'h0000;
      rdchk(7'h04, rv);
      wr(7'h04, rv & 16'h00ff);
      rdchk(7'h04, rv & 16'hff00);
      wr(7'h04, 16'hffff);
    end
    patternCheckEna = 1'b0;
    tick(1);
    lineFail = 16'hffff;
    tick(1);
    lineFail = 16'h0000;
    rdchk(7'h04, 16'h0000);
    $display("test line fail done");
    for (i = 0; i < 4; i = i + 1) begin
      tick(1);
      {patternMismatch, riseParityErr, fallParityErr, frameParityErr} = 4'h8 >> i;
      tick(1);
      {patternMismatch, riseParityErr, fallParityErr, frameParityErr} = 4'h0;
      rdchk(7'h05, (i == 0) ? 16'h0080 : (16'h0020 >> i));
      wr(7'h05, 16'hffff);
    end
    tick(1);
    fifoWrPtr = 8'h00;
    tick(2);
    shut(1'b0);
    chk({15'h0000, wrPtrStuck_r}, 16'h0001);
    rdchk(7'h05, 16'h8000);
    fifoWrPtr = 8'h01;
    clr;
    rdchk(7'h05, 16'h0000);
    for (i = 0; i < 8; i = i + 1) begin
      tick(1);
      {regAddr, fifoRdPtr} = {7'h05, 8'h01 << i};
      tick(1);
      fifoRdPtr = 8'h10;
      rdchk(7'h05, dist_flags(8'h01, 8'h01 << i));
      clr;
    end
    patternCheckEna = 1'b1;
    tick(1);
    patternMismatch = 1'b1;
    tick(1);
    patternMismatch = 1'b0;
    rdchk(7'h05, 16'h0080);
    patternCheckEna = 1'b0;
    clr;
    $display("test flags done");
    wr(7'h07, 16'hdeff);
    collisionGoneEna = 1'b1;
    fifoRdPtr = 8'h01;
    tick(1);
    fifoRdPtr = 8'h10;
    tick(3);
    shut(1'b1);
    chk(dacOutA_r, 16'h8000);
    rdchk(7'h05, 16'h2100);
    tick(8);
    shut(1'b1);
    clr;
    tick(3);
    shut(1'b0);
    chk(dacOutA_r, dataInA);
    $display("test collision done");
    collisionGoneEna = 1'b0;
    wr(7'h07, 16'hf8ff);
    dacClkGonePin = 1'b1;
    tick(8);
    shut(1'b0);
    rdchk(7'h05, 16'h0500);
    dacClkGoneEna = 1'b1;
    tick(3);
    shut(1'b1);
    dacClkGonePin = 1'b0;
    tick(6);
    clr;
    tick(3);
    shut(1'b0);
    dataClkGoneEna = 1'b1;
    linkRun = 1'b0;
    tick(140);
    rdchk(7'h05, 16'h0300);
    shut(1'b1);
    linkRun = 1'b1;
    tick(30);
    clr;
    tick(3);
    shut(1'b0);
    $display("test clock loss done");
    pllLockPin = 1'b0;
    tick(8);
    rdchk(7'h05, 16'h0020);
    pllLockPin = 1'b1;
    tick(6);
    clr;
    rdchk(7'h05, 16'h0000);
    $display("test pll done");
    give_verdict;
  end
endmodule
